// ===== rtl/ddr2_column_burst_odt_logic.sv
// column command decode, posted latency, burst data, strobes, termination and drive mode
`timescale 1ns/1ps
//
// Operation
// [RULE1] drive mode outputs on/off after fixed delay
// [RULE2] drive high/low patterns, complement strobes opposite
// [RULE3] controller selects patterns via calibration bits
// [RULE4] termination applies to all x16 data pins
// [RULE5] termination off in self refresh
// [RULE6] termination pin gates nominal switch set
// [RULE7] decode bits six and two as 75/150
// [RULE8] accept posted column commands, hold additive latency
// [RULE9] read data after additive plus CAS latency
// [RULE10] write latency equals read latency minus one
// [RULE11] early column commands need nonzero additive latency
// [RULE12] decode column access, write enable picks direction
// [RULE13] burst stays within aligned column group
// [RULE14] only same-direction interrupts at 4-beat boundary
// [RULE15] column commands spaced at least two clocks
// [RULE16] lengths four and eight, nibble sequential wrap
// [RULE17] mode register bit three picks burst type
// [RULE18] no burst stop command exists
// [RULE19] read decode gives starting column from address
// [RULE20] read strobe preamble one clock before data
// [RULE21] latencies from mode and extended mode registers
// [RULE22] strobes differential or single ended by bit
// [RULE23] back-to-back bursts without idle data cycles
// [RULE24] chip select high means no operation
module ddr2_column_burst_odt_logic (
   input  wire logic                                core_clk,
   input  wire logic                                rst_b,
   input  wire logic                                csIn_b,
   input  wire logic                                rasIn_b,
   input  wire logic                                casIn_b,
   input  wire logic                                weIn_b,
   input  wire logic [ddr2_col_pkg::BANK_W-1:0]     bankIn,
   input  wire logic [ddr2_col_pkg::ADDR_W-1:0]     addrIn,
   input  wire logic                                odtIn,
   input  wire logic                                selfRefresh,
   input  wire logic [ddr2_col_pkg::DQ_W-1:0]       dqInRise,
   input  wire logic [ddr2_col_pkg::DQ_W-1:0]       dqInFall,
   input  wire logic [ddr2_col_pkg::LANES-1:0]      dmInRise,
   input  wire logic [ddr2_col_pkg::LANES-1:0]      dmInFall,
   output logic      [ddr2_col_pkg::DQ_W-1:0]       dqOutRise,
   output logic      [ddr2_col_pkg::DQ_W-1:0]       dqOutFall,
   output logic                                     dqOutEn,
   output logic      [ddr2_col_pkg::LANES-1:0]      dqsOut,
   output logic      [ddr2_col_pkg::LANES-1:0]      dqsOutEn,
   output logic      [ddr2_col_pkg::LANES-1:0]      dqsNOut,
   output logic      [ddr2_col_pkg::LANES-1:0]      dqsNOutEn,
   output logic                                     term75,
   output logic                                     term150
);
   import ddr2_col_pkg::*;

   localparam int MEM_DEPTH = BANKS * (1 << MEM_COL_W);
   localparam int MEM_AW    = $clog2(MEM_DEPTH);
   localparam int LANE_W    = DQ_W / LANES;

   // command decode
   logic cmdSel;
   logic isColumn;
   logic isRead;
   logic isWrite;
   logic isActivate;
   logic isPrecharge;
   logic isModeSet;
   logic colAccept;

   // mode state
   logic [ADDR_W-1:0] modeReg;
   logic [ADDR_W-1:0] extModeReg;
   logic [BANKS-1:0]  bankOpen;
   logic [2:0]        casLat;
   logic [2:0]        addLat;
   logic [4:0]        readLat;
   logic [PIPE_TW-1:0] pipeTap;
   logic              burstLen8;
   logic              interleave;
   logic              diffStrobe;
   logic [1:0]        rttCode;
   logic [1:0]        lastPair;

   // read and write burst state
   logic              rdPend;
   logic [BANK_W-1:0] rdPendBank;
   logic [COL_W-1:0]  rdPendCol;
   logic              rdActive;
   logic [1:0]        rdPair;
   logic [BANK_W-1:0] rdBank;
   logic [COL_W-1:0]  rdCol;
   logic              wrPend;
   logic [BANK_W-1:0] wrPendBank;
   logic [COL_W-1:0]  wrPendCol;
   logic              wrActive;
   logic [1:0]        wrPair;
   logic [BANK_W-1:0] wrBank;
   logic [COL_W-1:0]  wrCol;
   logic [2:0]        rdOffRise;
   logic [2:0]        rdOffFall;
   logic [2:0]        wrOffRise;
   logic [2:0]        wrOffFall;
   logic [MEM_AW-1:0] rdAddrRise;
   logic [MEM_AW-1:0] rdAddrFall;
   logic [MEM_AW-1:0] wrAddrRise;
   logic [MEM_AW-1:0] wrAddrFall;
   logic [DQ_W-1:0]   mem [MEM_DEPTH];

   // drive mode state
   cal_state_e           calState;
   logic [CAL_CNT_W-1:0] calCnt;
   logic                 calHigh;
   logic [2:0]           calCode;
   logic                 calDriving;

   // registered output next values
   logic [DQ_W-1:0]  next_dqOutRise;
   logic [DQ_W-1:0]  next_dqOutFall;
   logic             next_dqOutEn;
   logic [LANES-1:0] next_dqsOut;
   logic [LANES-1:0] next_dqsOutEn;
   logic [LANES-1:0] next_dqsNOut;
   logic [LANES-1:0] next_dqsNOutEn;

   column_cmd_if #(.COL_W(COL_W), .BANK_W(BANK_W)) cmdIf ();
   column_cmd_if #(.COL_W(COL_W), .BANK_W(BANK_W)) execIf ();

   // command decode; nothing decodes as a burst stop
   assign cmdSel      = !csIn_b;                                       // [RULE24] [RULE18]
   assign isColumn    = cmdSel && rasIn_b && !casIn_b;                 // [RULE12]
   assign isRead      = isColumn && weIn_b;                            // [RULE19]
   assign isWrite     = isColumn && !weIn_b;                           // [RULE12]
   assign isActivate  = cmdSel && !rasIn_b && casIn_b && weIn_b;
   assign isPrecharge = cmdSel && !rasIn_b && casIn_b && !weIn_b;
   assign isModeSet   = cmdSel && !rasIn_b && !casIn_b && !weIn_b;
   assign colAccept   = (isRead || isWrite) && bankOpen[bankIn];       // [RULE8]

   // mode register fields
   assign casLat     = modeReg[MR_CL_LSB +: 3];                        // [RULE21]
   assign addLat     = extModeReg[EMR_AL_LSB +: 3];                    // [RULE21]
   assign readLat    = {2'h0, casLat} + {2'h0, addLat};                // [RULE9]
   assign burstLen8  = (modeReg[MR_BL_LSB +: 3] == BL_CODE_8);         // [RULE16]
   assign interleave = modeReg[MR_BT_BIT];                             // [RULE17]
   assign diffStrobe = !extModeReg[EMR_DQSN_OFF_BIT];                  // [RULE22]
   assign rttCode    = {extModeReg[EMR_RTT_HI_BIT], extModeReg[EMR_RTT_LO_BIT]}; // [RULE7]
   assign lastPair   = burstLen8 ? LAST_PAIR_BL8 : LAST_PAIR_BL4;      // [RULE16]
   assign calCode    = addrIn[EMR_CAL_LSB +: 3];

   // read and write share one tap: write latency is read latency minus one
   // and the write path has no output register stage
   assign pipeTap = (readLat < RL_TO_TAP) ? '0 : PIPE_TW'(readLat - RL_TO_TAP); // [RULE9] [RULE10]

   assign cmdIf.valid = colAccept;
   assign cmdIf.write = isWrite;
   assign cmdIf.bank  = bankIn;
   assign cmdIf.col   = addrIn[COL_W-1:0];                             // [RULE19]

   latency_pipe #(
      .DEPTH  (PIPE_DEPTH),
      .COL_W  (COL_W),
      .BANK_W (BANK_W)
   ) u_pipe (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .cmdIn    (cmdIf),
      .tap      (pipeTap),
      .cmdOut   (execIf)
   );                                                                  // [RULE8]

   // mode register writes
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         modeReg    <= MR_RESET;
         extModeReg <= EMR1_RESET;
      end else if (isModeSet && bankIn == BANK_MR) begin
         modeReg <= addrIn;
      end else if (isModeSet && bankIn == BANK_EMR1) begin
         extModeReg <= addrIn;
      end
   end

   // open banks
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         bankOpen <= '0;
      end else if (isActivate) begin
         bankOpen[bankIn] <= 1'b1;
      end else if (isPrecharge && addrIn[PRECHARGE_ALL_BIT]) begin
         bankOpen <= '0;
      end else if (isPrecharge) begin
         bankOpen[bankIn] <= 1'b0;
      end
   end

   // read burst: pending stage gives the preamble, a new pending burst restarts
   // the pair counter, which covers both seamless reads and 8-beat interrupts
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         rdPend   <= 1'b0;
         rdActive <= 1'b0;
         rdPair   <= 2'h0;
      end else begin
         rdPend <= execIf.valid && !execIf.write;
         if (rdPend) begin
            rdActive <= 1'b1;                                          // [RULE23] [RULE14] [RULE15]
            rdPair   <= 2'h0;
         end else if (rdActive && rdPair == lastPair) begin
            rdActive <= 1'b0;
         end else if (rdActive) begin
            rdPair <= rdPair + 2'h1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      rdPendBank <= execIf.bank;
      rdPendCol  <= execIf.col;
      if (rdPend) begin
         rdBank <= rdPendBank;
         rdCol  <= rdPendCol;
      end
   end

   // write burst: same structure, data captured while active
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         wrPend   <= 1'b0;
         wrActive <= 1'b0;
         wrPair   <= 2'h0;
      end else begin
         wrPend <= execIf.valid && execIf.write;                       // [RULE10]
         if (wrPend) begin
            wrActive <= 1'b1;                                          // [RULE23] [RULE14]
            wrPair   <= 2'h0;
         end else if (wrActive && wrPair == lastPair) begin
            wrActive <= 1'b0;
         end else if (wrActive) begin
            wrPair <= wrPair + 2'h1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      wrPendBank <= execIf.bank;
      wrPendCol  <= execIf.col;
      if (wrPend) begin
         wrBank <= wrPendBank;
         wrCol  <= wrPendCol;
      end
   end

   // beat ordering within the aligned group
   burst_order u_rd_rise (
      .start      (rdCol[2:0]),
      .beat       ({rdPair, 1'b0}),
      .burstLen8  (burstLen8),
      .interleave (interleave),
      .offset     (rdOffRise)
   );
   burst_order u_rd_fall (
      .start      (rdCol[2:0]),
      .beat       ({rdPair, 1'b1}),
      .burstLen8  (burstLen8),
      .interleave (interleave),
      .offset     (rdOffFall)
   );
   burst_order u_wr_rise (
      .start      (wrCol[2:0]),
      .beat       ({wrPair, 1'b0}),
      .burstLen8  (burstLen8),
      .interleave (interleave),
      .offset     (wrOffRise)
   );
   burst_order u_wr_fall (
      .start      (wrCol[2:0]),
      .beat       ({wrPair, 1'b1}),
      .burstLen8  (burstLen8),
      .interleave (interleave),
      .offset     (wrOffFall)
   );

   // upper group bits are kept, so a burst never leaves its group
   assign rdAddrRise = {rdBank, rdCol[MEM_COL_W-1:3], rdOffRise};      // [RULE13]
   assign rdAddrFall = {rdBank, rdCol[MEM_COL_W-1:3], rdOffFall};      // [RULE13]
   assign wrAddrRise = {wrBank, wrCol[MEM_COL_W-1:3], wrOffRise};      // [RULE13]
   assign wrAddrFall = {wrBank, wrCol[MEM_COL_W-1:3], wrOffFall};      // [RULE13]

   // write data capture with byte masks
   always_ff @(posedge core_clk) begin
      if (wrActive) begin
         for (int l = 0; l < LANES; l++) begin
            if (!dmInRise[l]) begin
               mem[wrAddrRise][l*LANE_W +: LANE_W] <= dqInRise[l*LANE_W +: LANE_W];
            end
            if (!dmInFall[l]) begin
               mem[wrAddrFall][l*LANE_W +: LANE_W] <= dqInFall[l*LANE_W +: LANE_W];
            end
         end
      end
   end

   // drive mode sequencing; a later mode write with code zero is the exit
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         calState <= CAL_IDLE;
         calCnt   <= '0;
         calHigh  <= 1'b0;
      end else if (isModeSet && bankIn == BANK_EMR1 &&
                   (calCode == CAL_DRIVE_HIGH || calCode == CAL_DRIVE_LOW)) begin
         calState <= CAL_ENTER;                                        // [RULE1] [RULE3]
         calCnt   <= CAL_CNT_W'(DRIVE_MODE_OUTPUT_DELAY_CYC);
         calHigh  <= (calCode == CAL_DRIVE_HIGH);
      end else if (isModeSet && bankIn == BANK_EMR1 && calCode == CAL_EXIT &&
                   calState != CAL_IDLE && calState != CAL_LEAVE) begin
         calState <= CAL_LEAVE;                                        // [RULE1] [RULE3]
         calCnt   <= CAL_CNT_W'(DRIVE_MODE_OUTPUT_DELAY_CYC);
      end else begin
         case (calState)
            CAL_ENTER: begin
               calCnt <= calCnt - 1'b1;
               if (calCnt == 1) begin
                  calState <= CAL_DRIVE;
               end
            end
            CAL_LEAVE: begin
               calCnt <= calCnt - 1'b1;
               if (calCnt == 1) begin
                  calState <= CAL_IDLE;
               end
            end
            CAL_DRIVE: begin
               calCnt <= '0;
            end
            default: begin
               calCnt <= '0;
            end
         endcase
      end
   end

   assign calDriving = (calState == CAL_ENTER && calCnt == 1) || calState == CAL_DRIVE ||
                       (calState == CAL_LEAVE && calCnt != 1);         // [RULE1]

   // output pins
   always_comb begin
      next_dqOutRise = '0;
      next_dqOutFall = '0;
      next_dqOutEn   = 1'b0;
      next_dqsOut    = '0;
      next_dqsOutEn  = '0;
      if (calDriving) begin
         next_dqOutRise = {DQ_W{calHigh}};                             // [RULE2]
         next_dqOutFall = {DQ_W{calHigh}};
         next_dqOutEn   = 1'b1;
         next_dqsOut    = {LANES{calHigh}};
         next_dqsOutEn  = '1;
      end else if (rdActive) begin
         next_dqOutRise = mem[rdAddrRise];                             // [RULE20]
         next_dqOutFall = mem[rdAddrFall];
         next_dqOutEn   = 1'b1;
         next_dqsOut    = '1;
         next_dqsOutEn  = '1;
      end else if (rdPend) begin
         next_dqsOut   = '0;                                           // [RULE20]
         next_dqsOutEn = '1;
      end
      next_dqsNOut   = ~next_dqsOut;                                   // [RULE2]
      next_dqsNOutEn = diffStrobe ? next_dqsOutEn : '0;                // [RULE22]
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         dqOutRise <= '0;
         dqOutFall <= '0;
         dqOutEn   <= 1'b0;
         dqsOut    <= '0;
         dqsOutEn  <= '0;
         dqsNOut   <= '1;
         dqsNOutEn <= '0;
      end else begin
         dqOutRise <= next_dqOutRise;
         dqOutFall <= next_dqOutFall;
         dqOutEn   <= next_dqOutEn;
         dqsOut    <= next_dqsOut;
         dqsOutEn  <= next_dqsOutEn;
         dqsNOut   <= next_dqsNOut;
         dqsNOutEn <= next_dqsNOutEn;
      end
   end

   // termination: one switch set for all data, strobe and mask pins
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         term75  <= 1'b0;
         term150 <= 1'b0;
      end else begin
         term75  <= odtIn && !selfRefresh && rttCode == RTT_75;        // [RULE4] [RULE5] [RULE6] [RULE7]
         term150 <= odtIn && !selfRefresh && rttCode == RTT_150;       // [RULE4] [RULE5] [RULE6] [RULE7]
      end
   end

   // early column commands rely on the controller having set additive latency
   // above zero; the device simply holds whatever additive latency is set [RULE11]
endmodule

// ===== rtl/ddr2_col_pkg.sv
// constants, field positions and types shared by the column burst and termination logic
package ddr2_col_pkg;
   localparam int ADDR_W = 14;
   localparam int DQ_W   = 16;
   localparam int COL_W  = 10;
   localparam int BANK_W = 2;
   localparam int BANKS  = 4;
   localparam int LANES  = 2;
   localparam int MEM_COL_W = 6;
   localparam int PIPE_DEPTH = 16;
   localparam int PIPE_TW = $clog2(PIPE_DEPTH);

   // mode register selection by bank address
   localparam logic [1:0] BANK_MR   = 2'h0;
   localparam logic [1:0] BANK_EMR1 = 2'h1;

   // values after reset: burst length 4, sequential, CAS latency 3, additive latency 0
   localparam logic [ADDR_W-1:0] MR_RESET   = 14'h0032;
   localparam logic [ADDR_W-1:0] EMR1_RESET = 14'h0000;

   // field positions
   localparam int MR_BL_LSB        = 0;
   localparam int MR_BT_BIT        = 3;
   localparam int MR_CL_LSB        = 4;
   localparam int EMR_RTT_LO_BIT   = 2;
   localparam int EMR_AL_LSB       = 3;
   localparam int EMR_RTT_HI_BIT   = 6;
   localparam int EMR_CAL_LSB      = 7;
   localparam int EMR_DQSN_OFF_BIT = 10;
   localparam int PRECHARGE_ALL_BIT = 10;

   // field codes
   localparam logic [2:0] BL_CODE_8      = 3'h3;
   localparam logic [2:0] CAL_EXIT       = 3'h0;
   localparam logic [2:0] CAL_DRIVE_HIGH = 3'h1;
   localparam logic [2:0] CAL_DRIVE_LOW  = 3'h2;
   localparam logic [1:0] RTT_75         = 2'h1;
   localparam logic [1:0] RTT_150        = 2'h2;

   // index of the last pair of a burst (two beats per clock)
   localparam logic [1:0] LAST_PAIR_BL4 = 2'h1;
   localparam logic [1:0] LAST_PAIR_BL8 = 2'h3;

   // pipe tap is read latency minus this (pending stage, burst active stage and output register)
   localparam logic [4:0] RL_TO_TAP = 5'h3;

   // output-on / output-off delay of the driver calibration drive mode
   localparam int CLK_PERIOD_NS = 40;
   localparam int DRIVE_MODE_OUTPUT_DELAY_NS = 12;
   localparam int DRIVE_MODE_OUTPUT_DELAY_CYC_RAW =
      (DRIVE_MODE_OUTPUT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DRIVE_MODE_OUTPUT_DELAY_CYC =
      (DRIVE_MODE_OUTPUT_DELAY_CYC_RAW < 1) ? 1 : DRIVE_MODE_OUTPUT_DELAY_CYC_RAW;
   localparam int CAL_CNT_W = 8;

   typedef enum {CAL_IDLE, CAL_ENTER, CAL_DRIVE, CAL_LEAVE} cal_state_e;
endpackage

// ===== rtl/column_cmd_if.sv
// column command carrier between the decoder and the latency pipe
`timescale 1ns/1ps
interface column_cmd_if #(
   parameter int COL_W  = 10,
   parameter int BANK_W = 2
);
   logic              valid;
   logic              write;
   logic [BANK_W-1:0] bank;
   logic [COL_W-1:0]  col;

   modport source (output valid, output write, output bank, output col);
   modport sink   (input valid, input write, input bank, input col);
endinterface

// ===== rtl/latency_pipe.sv
// shift pipe that holds posted column commands until a selectable tap
`timescale 1ns/1ps
module latency_pipe #(
   parameter int DEPTH  = 16,
   parameter int COL_W  = 10,
   parameter int BANK_W = 2
) (
   input  wire logic                       core_clk,
   input  wire logic                       rst_b,
   column_cmd_if.sink                      cmdIn,
   input  wire logic [$clog2(DEPTH)-1:0]   tap,
   column_cmd_if.source                    cmdOut
);
   localparam int SW = 1 + BANK_W + COL_W;

   logic [DEPTH-1:0] slotValid;
   logic [SW-1:0]    slot [DEPTH];

   if (DEPTH < 4) begin : g_bad_depth
      $error("latency_pipe depth must be at least 4");
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         slotValid <= '0;
      end else begin
         slotValid <= {slotValid[DEPTH-2:0], cmdIn.valid};
      end
   end

   always_ff @(posedge core_clk) begin
      slot[0] <= {cmdIn.write, cmdIn.bank, cmdIn.col};
      for (int i = 1; i < DEPTH; i++) begin
         slot[i] <= slot[i-1];
      end
   end

   assign cmdOut.valid = slotValid[tap];
   assign {cmdOut.write, cmdOut.bank, cmdOut.col} = slot[tap];
endmodule

// ===== rtl/burst_order.sv
// column offset of one beat inside its aligned burst group
`timescale 1ns/1ps
module burst_order (
   input  wire logic [2:0] start,
   input  wire logic [2:0] beat,
   input  wire logic       burstLen8,
   input  wire logic       interleave,
   output logic      [2:0] offset
);
   logic [1:0] lowSum;

   assign lowSum = start[1:0] + beat[1:0];
   // bit 2 only moves in 8-beat bursts; sequential wraps per nibble
   assign offset[2]   = start[2] ^ (burstLen8 & beat[2]);
   assign offset[1:0] = interleave ? (start[1:0] ^ beat[1:0]) : lowSum;
endmodule

// ===== test/ddr2_col_sva.sv
// assertions on the read, strobe and termination pins
`timescale 1ns/1ps
module ddr2_col_sva (
   input wire logic        core_clk,
   input wire logic        rst_b,
   input wire logic        csIn_b,
   input wire logic        rasIn_b,
   input wire logic        casIn_b,
   input wire logic        weIn_b,
   input wire logic [1:0]  bankIn,
   input wire logic [13:0] addrIn,
   input wire logic        odtIn,
   input wire logic        selfRefresh,
   input wire logic        dqOutEn,
   input wire logic [1:0]  dqsOut,
   input wire logic [1:0]  dqsOutEn,
   input wire logic [1:0]  dqsNOut,
   input wire logic        term75,
   input wire logic        term150
);
   logic [2:0] al;
   logic [1:0] rtt;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // copies of additive latency and termination code
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         al  <= 3'h0;
         rtt <= 2'h0;
      end else if ({csIn_b, rasIn_b, casIn_b, weIn_b, bankIn} == 6'h01) begin
         al  <= addrIn[5:3];
         rtt <= {addrIn[6], addrIn[2]};
      end
   end
   sequence rdCmd; {csIn_b, rasIn_b, casIn_b, weIn_b} == 4'h5 && al == 3'h0; endsequence
   sequence pre; dqsOutEn == 2'h3 && dqsOut == 2'h0 && !dqOutEn; endsequence
   a_read_latency: assert property (rdCmd |-> ##3 pre ##1 dqOutEn)
      else $error("read data late or early");
   a_preamble_next: assert property (pre |=> dqOutEn && dqsOut == 2'h3)
      else $error("no data after preamble");
   a_data_strobe: assert property (dqOutEn |-> dqsOutEn == 2'h3)
      else $error("data without strobes");
   a_burst_min: assert property ($rose(dqOutEn) |-> dqOutEn [*2])
      else $error("burst shorter than four beats");
   a_strobe_inverse: assert property (dqsOutEn != 2'h0 |-> dqsNOut == ~dqsOut)
      else $error("complement strobe wrong");
   a_term_exclusive: assert property (!(term75 && term150))
      else $error("two termination sets closed");
   a_term_gate: assert property (!odtIn || selfRefresh |=> !term75 && !term150)
      else $error("termination not off");
   a_term_code: assert property (csIn_b && odtIn && !selfRefresh |=>
      {term75, term150} == {rtt == 2'h1, rtt == 2'h2}) else $error("wrong termination set");
endmodule
bind ddr2_column_burst_odt_logic ddr2_col_sva i_sva (.core_clk, .rst_b, .csIn_b, .rasIn_b, .casIn_b,
   .weIn_b, .bankIn, .addrIn, .odtIn, .selfRefresh, .dqOutEn, .dqsOut, .dqsOutEn, .dqsNOut, .term75, .term150);

// ===== test/ddr2_ctrl_model.sv
// controller model driving command pins and write data
`timescale 1ns/1ps
module ddr2_ctrl_model (
   input  wire logic  core_clk,
   output logic       csIn_b,
   output logic       rasIn_b,
   output logic       casIn_b,
   output logic       weIn_b,
   output logic [1:0] bankIn,
   output logic [13:0] addrIn,
   output logic [15:0] dqInRise,
   output logic [15:0] dqInFall
);
   initial begin
      {csIn_b, rasIn_b, casIn_b, weIn_b, bankIn, addrIn} = {4'hF, 16'h0000};
      {dqInRise, dqInFall} = 32'h0000FFFF;
   end
   // one command per call, then deselect; no burst stop code is ever sent
   // callers keep column commands two clocks apart and never cut a burst short
   // drive patterns only through the three calibration bits
   task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [13:0] a);
      @(negedge core_clk);
      {csIn_b, rasIn_b, casIn_b, weIn_b, bankIn, addrIn} = {c, b, a};
      @(negedge core_clk);
      csIn_b = 1'b1;
      addrIn = ~a;
   endtask
   // write beats placed one clock ahead of read latency
   task automatic put(input logic f, input logic [15:0] d);
      if (f) dqInFall = d;
      else dqInRise = d;
   endtask
   task automatic rest;
      {dqInRise, dqInFall} = ~{dqInRise, dqInFall};
   endtask
endmodule

// ===== test/ddr2_column_burst_odt_logic_tb.sv
// self-checking bench for the column burst and termination logic
`timescale 1ns/1ps
module ddr2_column_burst_odt_logic_tb;
   import ddr2_col_pkg::*;
   logic        core_clk, rst_b, odtIn, selfRefresh, csIn_b, rasIn_b, casIn_b, weIn_b, dqOutEn, term75, term150;
   logic [1:0]  bankIn, dmInRise, dmInFall, dqsOut, dqsOutEn, dqsNOut, dqsNOutEn;
   logic [13:0] addrIn;
   logic [15:0] dqInRise, dqInFall, dqOutRise, dqOutFall;
   logic [15:0] mem [256];
   int          err_count, tests_run;
   ddr2_column_burst_odt_logic i_dut (.core_clk, .rst_b, .csIn_b, .rasIn_b, .casIn_b, .weIn_b, .bankIn,
      .addrIn, .odtIn, .selfRefresh, .dqInRise, .dqInFall, .dmInRise, .dmInFall, .dqOutRise, .dqOutFall,
      .dqOutEn, .dqsOut, .dqsOutEn, .dqsNOut, .dqsNOutEn, .term75, .term150);
   ddr2_ctrl_model i_ctrl (.core_clk, .csIn_b, .rasIn_b, .casIn_b, .weIn_b, .bankIn, .addrIn, .dqInRise,
      .dqInFall);
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   task automatic compare(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // column offset of a beat inside its group
   function automatic logic [2:0] ofs(input logic [2:0] s, input logic [2:0] b, input logic bl8, input logic il);
      logic [2:0] o;
      o[1:0] = il ? s[1:0] ^ b[1:0] : s[1:0] + b[1:0];
      o[2] = bl8 ? s[2] ^ b[2] : s[2];
      return o;
   endfunction
   // write a burst, read it back from a random start in the same group
   task automatic burst(input logic [1:0] bk, input logic bl8, input logic il);
      logic [13:0] col, rc;
      logic [15:0] d;
      int          al, n;
      n = bl8 ? 8 : 4;
      al = 2 * int'($urandom % 2);
      col = 14'($urandom);
      rc = bl8 ? {col[13:3], 3'($urandom)} : {col[13:2], 2'($urandom)};
      i_ctrl.cmd(4'h0, 2'h0, {7'h00, 3'h3, il, bl8 ? 3'h3 : 3'h2});
      i_ctrl.cmd(4'h0, 2'h1, {8'h00, 3'(al), 3'h0});
      i_ctrl.cmd(4'h3, bk, 14'h0000);
      if (al == 0) repeat (2) @(negedge core_clk);
      i_ctrl.cmd(4'h4, bk, col);
      repeat (al + 2) @(negedge core_clk);
      for (int k = 0; k < n; k++) begin
         d = 16'($urandom);
         mem[{bk, col[5:3], ofs(col[2:0], 3'(k), bl8, il)}] = d;
         i_ctrl.put(k[0], d);
         if (k[0]) @(negedge core_clk);
      end
      i_ctrl.rest();
      repeat (2) @(negedge core_clk);
      i_ctrl.cmd(4'h5, bk, rc);
      repeat (al + 2) @(negedge core_clk);
      compare(16'({dqsOutEn, dqsOut, dqOutEn}), 16'h0018);
      for (int k = 0; k < n; k++) begin
         if (!k[0]) @(negedge core_clk);
         compare(k[0] ? dqOutFall : dqOutRise, mem[{bk, rc[5:3], ofs(rc[2:0], 3'(k), bl8, il)}]);
      end
      @(negedge core_clk);
      compare(16'({dqsOutEn, dqOutEn}), 16'h0000);
      i_ctrl.cmd(4'hD, bk, rc);
      repeat (6) @(negedge core_clk) compare(16'({dqsOutEn, dqOutEn}), 16'h0000);
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      {rst_b, odtIn, selfRefresh, dmInRise, dmInFall} = 7'h00;
      {err_count, tests_run} = 64'h0;
      void'($urandom(32'h7E30));
      repeat (3) @(negedge core_clk);
      rst_b = 1'b1;
      compare(16'({dqOutEn, dqsOutEn, dqsNOut, term75, term150}), 16'h000C);
      for (int i = 0; i < 4; i++) burst(2'(i), i[1], i[0]);
      for (int i = 0; i < 16; i++) begin
         i_ctrl.cmd(4'h0, 2'h1, {7'h00, i[1], 3'h0, i[0], 2'h0});
         {odtIn, selfRefresh} = {i[2], i[3]};
         repeat (2) @(negedge core_clk);
         compare(16'({term75, term150}),
            (i[2] && !i[3]) ? 16'({i[1:0] == RTT_75, i[1:0] == RTT_150}) : 16'h0);
      end
      odtIn = 1'b0;
      for (int p = 1; p < 3; p++) begin
         i_ctrl.cmd(4'h0, 2'h1, {3'h0, p == 2, 3'(p), 7'h00});
         compare(16'(dqOutEn), 16'h0000);
         repeat (DRIVE_MODE_OUTPUT_DELAY_CYC) @(negedge core_clk);
         compare(dqOutRise, {16{p == 1}});
         compare(dqOutFall, {16{p == 1}});
         compare(16'({dqOutEn, dqsOutEn, dqsOut, dqsNOut, dqsNOutEn}),
            (p == 1) ? 16'h01F3 : 16'h01CC);
         i_ctrl.cmd(4'h0, 2'h1, 14'h0000);
         repeat (DRIVE_MODE_OUTPUT_DELAY_CYC) @(negedge core_clk);
         compare(16'({dqOutEn, dqsOutEn, dqsNOutEn}), 16'h0000);
      end
      complete_run();
   end
endmodule
